// *** testbench/flash_status_props.sv ***
`timescale 1ns/1ps
module flash_status_props
	import flash_status_pkg::*;
(
	// Clock and reset
	input  wire logic              MCLK_I,
	input  wire logic              RESET_N_I,
	// Bus signals
	input  wire logic              ce_n,
	input  wire logic              oe_n,
	input  wire logic              we_n,
	input  wire logic [DATA_W-1:0] dq,
	input  wire logic              host_dq_oe,
	input  wire logic              dev_dq_oe,
	// Device observation
	input  wire logic              BUSY_O,
	input  wire logic [STAT_W-1:0] STATUS_O
);
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	logic       we_q;
	logic       wr_take;
	logic [7:0] since_clr;
	logic [7:0] since_susp;

	// Write is taken on the edge after write enable rises with chip enable low
	assign wr_take = !we_q && we_n && !ce_n;

	// Age of the last clear and suspend writes, saturating so old ones never wrap
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			we_q <= 1'b1;
			since_clr <= 8'hff;
			since_susp <= 8'hff;
		end
		else
		begin
			we_q <= we_n;
			since_clr <= (wr_take && dq[7:0] == CMD_CLEAR) ? 8'h00 : since_clr + {7'h00, since_clr != 8'hff};
			since_susp <= (wr_take && dq[7:0] == CMD_SUSPEND) ? 8'h00 : since_susp + {7'h00, since_susp != 8'hff};
		end
	end

	a_bus_no_clash: assert property (!(dev_dq_oe && host_dq_oe))
		else $error("both ends drive the data bus");
	a_read_drive_timing: assert property (dev_dq_oe == $past(!ce_n && !oe_n))
		else $error("device output enable does not follow the read strobes");
	a_busy_not_ready: assert property (BUSY_O [*3] |-> !STATUS_O[READY_POS])
		else $error("ready bit high while busy");
	a_idle_is_ready: assert property (!BUSY_O [*3] |-> STATUS_O[READY_POS])
		else $error("ready bit low while idle");
	a_ready_bank_low: assert property (STATUS_O[READY_POS] |-> !STATUS_O[BANKW_POS])
		else $error("bank bit high while ready");
	a_susp_one_kind: assert property (!(STATUS_O[ESUSP_POS] && STATUS_O[PSUSP_POS]))
		else $error("both suspend bits set");
	a_susp_means_ready: assert property ((STATUS_O[ESUSP_POS] || STATUS_O[PSUSP_POS]) |-> STATUS_O[READY_POS])
		else $error("suspend bit set while controller busy");
	a_susp_latency: assert property ($rose(STATUS_O[ESUSP_POS] || STATUS_O[PSUSP_POS])
		|-> since_susp >= 8'h10 && since_susp <= 8'h1e)
		else $error("suspend bit rose outside the suspend latency");
	a_error_sticky: assert property (|($past(STATUS_O) & ~STATUS_O & 8'h3a) |-> since_clr <= 8'h04)
		else $error("error bit fell without a clear command");
	a_resume_clears: assert property (wr_take && dq[7:0] == CMD_RESUME && (STATUS_O[ESUSP_POS] || STATUS_O[PSUSP_POS])
		|-> ##[1:3] !(STATUS_O[ESUSP_POS] || STATUS_O[PSUSP_POS]))
		else $error("suspend bit kept after resume");

	// Main scenarios reached
	c_erase_susp: cover property (STATUS_O[ESUSP_POS]);
	c_prog_susp: cover property (STATUS_O[PSUSP_POS]);
	c_other_bank: cover property (!STATUS_O[READY_POS] && STATUS_O[BANKW_POS]);
endmodule

// *** testbench/tb_flash_program_erase_status.sv ***
`timescale 1ns/1ps
module tb_flash_program_erase_status;
	import flash_status_pkg::*;
	localparam logic [ADDR_W-1:0] BANK_A = 23'h000100;
	localparam logic [ADDR_W-1:0] BANK_B = 23'h400000;
	localparam logic [DATA_W-1:0] ARRAY_WORD = 16'hbeef;

	logic              mclk = 1'b0;
	logic              rst_n = 1'b0;
	logic              vpp_valid = 1'b1;
	logic              vpp_high = 1'b0;
	logic              locked = 1'b0;
	logic              verify = 1'b1;
	logic              blank_fail = 1'b0;
	logic              overwrite = 1'b0;
	logic              cmd_valid = 1'b0;
	logic              cmd_write = 1'b0;
	logic [ADDR_W-1:0] cmd_addr = '0;
	logic [DATA_W-1:0] cmd_data = '0;
	logic              cmd_ready;
	logic              rd_valid;
	logic [DATA_W-1:0] rd_data;
	logic [3:0]        flags;
	logic              busy;
	logic [STAT_W-1:0] status;
	logic [DATA_W-1:0] d;
	logic [DATA_W-1:0] junk;
	int                mismatches = 0;
	int                comparisons = 0;
	int                cycles = 0;

	flash_bus_if flash_bus_if_i ();
	flash_pe_device flash_pe_device_i (.MCLK_I(mclk), .RESET_N_I(rst_n), .BUS(flash_bus_if_i.device),
		.ARRAY_DATA_I(ARRAY_WORD), .VPP_VALID_I(vpp_valid), .VPP_HIGH_I(vpp_high), .BLOCK_LOCKED_I(locked),
		.VERIFY_PASS_I(verify), .BLANK_FAIL_I(blank_fail), .OVERWRITE_I(overwrite), .BUSY_O(busy), .STATUS_O(status));
	flash_pe_host flash_pe_host_i (.MCLK_I(mclk), .RESET_N_I(rst_n), .BUS(flash_bus_if_i.host),
		.CMD_VALID_I(cmd_valid), .CMD_WRITE_I(cmd_write), .CMD_ADDR_I(cmd_addr), .CMD_DATA_I(cmd_data),
		.CMD_READY_O(cmd_ready), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data), .FLAGS_O(flags));
	flash_status_props flash_status_props_i (.MCLK_I(mclk), .RESET_N_I(rst_n), .ce_n(flash_bus_if_i.ce_n),
		.oe_n(flash_bus_if_i.oe_n), .we_n(flash_bus_if_i.we_n), .dq(flash_bus_if_i.dq),
		.host_dq_oe(flash_bus_if_i.host_dq_oe), .dev_dq_oe(flash_bus_if_i.dev_dq_oe), .BUSY_O(busy), .STATUS_O(status));

	// Clock
	always #12.5 mclk = ~mclk;

	// Hang guard, well above the few thousand cycles the traffic needs
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Inputs change one step after the edge so sampling never races
	task automatic step();
		@(posedge mclk);
		#1;
	endtask

	// One user request; reads wait for the answer pulse
	task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
		output logic [DATA_W-1:0] rd_word);
		for (int n = 0; n < 20 && cmd_ready !== 1'b1; n++)
			step();
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_addr = a;
		cmd_data = wd;
		step();
		cmd_valid = 1'b0;
		for (int n = 0; n < 12 && !wr && rd_valid !== 1'b1; n++)
			step();
		rd_word = rd_data;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
		access(1'b1, a, wd, junk);
	endtask

	task automatic cmd(input logic [7:0] c);
		wr(BANK_A, {8'h00, c});
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		access(1'b0, a, '0, d);
	endtask

	// Status reads until the controller reports ready
	task automatic poll();
		d = '0;
		for (int n = 0; n < 100 && d[READY_POS] !== 1'b1; n++)
			rd(BANK_A);
	endtask

	task automatic program_word(input logic [DATA_W-1:0] w);
		cmd(CMD_PROGRAM);
		wr(BANK_A, w);
	endtask

	task automatic t_reset();
		cmd(CMD_READ_ARRAY);
		rd(BANK_A);
		check(d, ARRAY_WORD);
		cmd(CMD_READ_STATUS);
		rd(BANK_A);
		check(d, 16'h0080);
	endtask

	task automatic t_erase_fail();
		verify = 1'b0;
		cmd(CMD_ERASE);
		rd(BANK_A);
		check(d, 16'h0000);
		rd(BANK_B);
		check(d, 16'h0001);
		check({12'h000, flags}, 16'h0001);
		cmd(CMD_READ_ARRAY);
		rd(BANK_A);
		check(d, ARRAY_WORD);
		cmd(CMD_READ_STATUS);
		poll();
		check(d, 16'h00a0);
		check({12'h000, flags}, 16'h0008);
		cmd(CMD_ERASE);
		rd(BANK_A);
		check(d, 16'h00a0);
		cmd(CMD_CLEAR);
		rd(BANK_A);
		check(d, 16'h0080);
		verify = 1'b1;
	endtask

	task automatic t_program();
		verify = 1'b0;
		program_word(16'h1234);
		poll();
		check(d, 16'h0090);
		program_word(16'h1234);
		rd(BANK_A);
		check(d, 16'h0090);
		cmd(CMD_CLEAR);
		verify = 1'b1;
		overwrite = 1'b1;
		vpp_high = 1'b1;
		program_word(16'h1234);
		poll();
		check(d, 16'h0090);
		cmd(CMD_CLEAR);
		vpp_high = 1'b0;
		program_word(16'h1234);
		poll();
		check(d, 16'h0080);
		overwrite = 1'b0;
	endtask

	task automatic t_supply_lock_blank();
		vpp_valid = 1'b0;
		cmd(CMD_ERASE);
		poll();
		check(d, 16'h0088);
		cmd(CMD_CLEAR);
		vpp_valid = 1'b1;
		cmd(CMD_READ_ARRAY);
		cmd(CMD_ERASE);
		// Drop the supply only once the launch has happened
		for (int n = 0; n < 10 && busy !== 1'b1; n++)
			step();
		check({15'h0000, busy}, 16'h0001);
		vpp_valid = 1'b0;
		rd(BANK_A);
		check(d, 16'h0000);
		rd(BANK_B);
		check(d, ARRAY_WORD);
		cmd(CMD_READ_STATUS);
		poll();
		check(d, 16'h0080);
		vpp_valid = 1'b1;
		locked = 1'b1;
		program_word(16'h1234);
		poll();
		check(d, 16'h0082);
		cmd(CMD_ERASE);
		rd(BANK_A);
		check(d, 16'h0082);
		cmd(CMD_CLEAR);
		locked = 1'b0;
		blank_fail = 1'b1;
		cmd(CMD_BLANK);
		poll();
		check(d, 16'h00a0);
		cmd(CMD_CLEAR);
		blank_fail = 1'b0;
		cmd(CMD_BLANK);
		poll();
		check(d, 16'h0080);
	endtask

	task automatic t_suspend();
		verify = 1'b0;
		cmd(CMD_ERASE);
		cmd(CMD_SUSPEND);
		rd(BANK_A);
		check({15'h0000, d[READY_POS]}, 16'h0000);
		poll();
		check(d, 16'h00c0);
		check({12'h000, flags}, 16'h0004);
		verify = 1'b1;
		cmd(CMD_RESUME);
		rd(BANK_A);
		check({14'h0000, d[7:6]}, 16'h0000);
		poll();
		verify = 1'b0;
		program_word(16'h1234);
		cmd(CMD_SUSPEND);
		poll();
		check(d, 16'h0084);
		check({12'h000, flags}, 16'h0002);
		verify = 1'b1;
		cmd(CMD_RESUME);
		rd(BANK_A);
		check({15'h0000, d[PSUSP_POS]}, 16'h0000);
		poll();
		check(d, 16'h0080);
	endtask

	task automatic t_factory();
		cmd(CMD_BUFFERED_FACTORY_PROGRAM_MODE);
		wr(BANK_A, 16'h5555);
		rd(BANK_A);
		check({14'h0000, d[READY_POS], d[BANKW_POS]}, 16'h0001);
		repeat (40) step();
		rd(BANK_A);
		check({14'h0000, d[READY_POS], d[BANKW_POS]}, 16'h0000);
		wr(BUFFERED_FACTORY_PROGRAM_MODE_EXIT_ADDR, 16'haaaa);
		poll();
		check(d, 16'h0080);
	endtask

	// Main sequence
	initial
	begin
		repeat (4) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_erase_fail();
		t_program();
		t_supply_lock_blank();
		t_suspend();
		t_factory();
		end_of_test();
	end
endmodule

// *** verilog/flash_bus_if.sv ***
`timescale 1ns/1ps
interface flash_bus_if;
	import flash_status_pkg::*;
	logic              ce_n;
	logic              oe_n;
	logic              we_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] host_dq;
	logic              host_dq_oe;
	logic [DATA_W-1:0] dev_dq;
	logic              dev_dq_oe;
	logic [DATA_W-1:0] dq;

	// Resolved data bus, pulled high when nobody drives
	assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : {DATA_W{1'b1}});

	modport host (output ce_n, oe_n, we_n, addr, host_dq, host_dq_oe, input dq);
	modport device (input ce_n, oe_n, we_n, addr, dq, output dev_dq, dev_dq_oe);
endinterface

// *** verilog/flash_pe_device.sv ***
// Operation
// - Ready bit low while controller busy
// - Ready stays low until suspend completes
// - Erase-suspended set when erase paused
// - Resume clears erase-suspended
// - Host trusts suspend bits only when ready
// - Erase pulses exhausted sets erase error
// - Blank check non-ones sets erase error
// - Error bits sticky until clear or reset
// - Pending supply, protection or same-kind error makes new command fail
// - Program pulses exhausted sets program error
// - Overwrite sets program error only at high supply
// - Supply sampled only at operation start
// - Low supply sets supply error, aborts
// - Program-suspended set when program paused
// - Resume clears program-suspended
// - Locked block access sets protection error; blank check is exempt from the lock test here
// - Bank bit shows busy bank versus other
// - Host trusts bank bit only when busy
// - Factory mode bank bit shows word readiness
// - Host reads errors after ready returns
// - Status latched on enable falling edge
// - Busy bank reads return status; once a read array command follows the launch, they return array data here
`timescale 1ns/1ps
module flash_pe_device
	import flash_status_pkg::*;
(
	// Clock and reset
	input  wire logic              MCLK_I,
	input  wire logic              RESET_N_I,
	// Flash bus
	flash_bus_if.device            BUS,
	// Array and supply side
	input  wire logic [DATA_W-1:0] ARRAY_DATA_I,
	input  wire logic              VPP_VALID_I,
	input  wire logic              VPP_HIGH_I,
	input  wire logic              BLOCK_LOCKED_I,
	input  wire logic              VERIFY_PASS_I,
	input  wire logic              BLANK_FAIL_I,
	input  wire logic              OVERWRITE_I,
	// Observation
	output logic                   BUSY_O,
	output logic      [STAT_W-1:0] STATUS_O
);
	import flash_status_pkg::*;

	pe_state_t         state;
	op_kind_t          op_kind;
	logic [BANK_W-1:0] op_bank;
	logic [CNT_W-1:0]  tick_cnt;
	logic [CNT_W-1:0]  pulse_cnt;
	logic [CNT_W-1:0]  lat_cnt;
	logic              we_n_q;
	logic              await_data;
	logic              in_buffered_factory_program_mode;
	logic              buffered_factory_program_mode_busy;
	logic [CNT_W-1:0]  buffered_factory_program_mode_tick;
	logic              rs_mode;
	logic              op_reads_status;
	logic              erase_err;
	logic              prog_err;
	logic              supply_err;
	logic              prot_err;
	logic              erase_susp;
	logic              prog_susp;
	logic [STAT_W-1:0] live_status;
	logic [STAT_W-1:0] held_status;

	logic       wr_take;
	logic [7:0] cmd;
	logic       ready;
	logic       bank_write;
	logic       pulse_end;
	logic       op_done;
	logic       op_fail;
	logic       req_erase;
	logic       req_prog;
	logic       blocked;
	logic       launch;
	logic       abort_supply;
	logic       abort_prot;
	logic       abort_over;
	logic       go_run;
	logic       suspend_cmd;
	logic       resume_cmd;
	logic       clear_cmd;

	// Write cycle taken as we_n rises under chip enable
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			we_n_q <= 1'b1;
		else
			we_n_q <= BUS.we_n;
	end
	assign wr_take = !we_n_q && BUS.we_n && !BUS.ce_n;
	assign cmd     = BUS.dq[7:0];

	// Command decode
	assign ready       = (state == ST_READY || state == ST_SUSPENDED) && !in_buffered_factory_program_mode;
	assign clear_cmd   = wr_take && !await_data && !in_buffered_factory_program_mode && cmd == CMD_CLEAR;
	assign suspend_cmd = wr_take && !await_data && cmd == CMD_SUSPEND && state == ST_RUN && op_kind != OP_BLANK;
	assign resume_cmd  = wr_take && !await_data && cmd == CMD_RESUME && state == ST_SUSPENDED;
	assign req_erase   = wr_take && !await_data && !in_buffered_factory_program_mode && state == ST_READY
		&& (cmd == CMD_ERASE || cmd == CMD_BLANK);
	assign req_prog    = wr_take && await_data;
	// A still-set supply, protection or same-kind error swallows the new command, leaving the flags as the failure report
	assign blocked     = supply_err || prot_err || (req_prog ? prog_err : erase_err);
	assign launch      = (req_erase || req_prog) && !blocked;
	// Supply and lock are looked at only here, at launch
	assign abort_supply = !VPP_VALID_I;
	assign abort_prot   = BLOCK_LOCKED_I && !(req_erase && cmd == CMD_BLANK);
	assign abort_over   = req_prog && OVERWRITE_I && VPP_HIGH_I;
	assign go_run       = launch && !abort_supply && !abort_prot && !abort_over;

	// Pulse outcome
	assign pulse_end = (state == ST_RUN || state == ST_SUSP_WAIT) && tick_cnt == '0;
	assign op_fail   = pulse_end && (op_kind == OP_BLANK ? BLANK_FAIL_I : (!VERIFY_PASS_I
		&& pulse_cnt + 8'h01 == (op_kind == OP_ERASE ? MAX_ERASE_PULSES : MAX_PROG_PULSES)));
	assign op_done   = pulse_end && (op_kind == OP_BLANK || VERIFY_PASS_I || op_fail);

	// Program waits for its data word
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			await_data <= 1'b0;
		else if (wr_take)
			await_data <= !await_data && !in_buffered_factory_program_mode && state == ST_READY && cmd == CMD_PROGRAM;
	end

	// Controller sequencing
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			state     <= ST_READY;
			op_kind   <= OP_ERASE;
			op_bank   <= '0;
			tick_cnt  <= '0;
			pulse_cnt <= '0;
			lat_cnt   <= '0;
		end
		else
		begin
			case (state)
				ST_READY:
				begin
					if (go_run)
					begin
						state     <= ST_RUN;
						op_kind   <= req_prog ? OP_PROGRAM : (cmd == CMD_BLANK ? OP_BLANK : OP_ERASE);
						op_bank   <= bank_of(BUS.addr);
						tick_cnt  <= PULSE_CYCLES - 8'h01;
						pulse_cnt <= '0;
					end
				end
				ST_RUN, ST_SUSP_WAIT:
				begin
					if (op_done)
						state <= ST_READY;
					else if (state == ST_SUSP_WAIT && lat_cnt == '0)
						state <= ST_SUSPENDED;
					else if (suspend_cmd)
					begin
						state   <= ST_SUSP_WAIT;
						lat_cnt <= SUSP_LAT_CYCLES - 8'h01;
					end
					if (state == ST_SUSP_WAIT && lat_cnt != '0)
						lat_cnt <= lat_cnt - 8'h01;
					if (pulse_end)
					begin
						tick_cnt  <= PULSE_CYCLES - 8'h01;
						pulse_cnt <= pulse_cnt + 8'h01;
					end
					else
						tick_cnt <= tick_cnt - 8'h01;
				end
				ST_SUSPENDED:
				begin
					if (resume_cmd)
						state <= ST_RUN;
				end
				default:
					state <= ST_READY;
			endcase
		end
	end

	// Sticky error flags; a set in the clearing cycle wins
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			erase_err  <= 1'b0;
			prog_err   <= 1'b0;
			supply_err <= 1'b0;
			prot_err   <= 1'b0;
		end
		else
		begin
			erase_err  <= (erase_err && !clear_cmd) || (op_fail && op_kind != OP_PROGRAM);
			prog_err   <= (prog_err && !clear_cmd) || (op_fail && op_kind == OP_PROGRAM)
				|| (launch && !abort_supply && !abort_prot && abort_over);
			supply_err <= (supply_err && !clear_cmd) || (launch && abort_supply);
			prot_err   <= (prot_err && !clear_cmd) || (launch && !abort_supply && abort_prot);
		end
	end

	// Suspend flags follow the pause and the resume
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			erase_susp <= 1'b0;
			prog_susp  <= 1'b0;
		end
		else if (resume_cmd)
		begin
			erase_susp <= 1'b0;
			prog_susp  <= 1'b0;
		end
		else if (state == ST_SUSP_WAIT && lat_cnt == '0 && !op_done)
		begin
			erase_susp <= op_kind == OP_ERASE;
			prog_susp  <= op_kind == OP_PROGRAM;
		end
	end

	// Factory mode: each word busies the array for one pulse
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			in_buffered_factory_program_mode   <= 1'b0;
			buffered_factory_program_mode_busy <= 1'b0;
		end
		else
		begin
			if (!in_buffered_factory_program_mode)
				in_buffered_factory_program_mode <= wr_take && !await_data && state == ST_READY && cmd == CMD_BUFFERED_FACTORY_PROGRAM_MODE && !blocked;
			else if (wr_take && !buffered_factory_program_mode_busy)
				in_buffered_factory_program_mode <= BUS.addr != BUFFERED_FACTORY_PROGRAM_MODE_EXIT_ADDR;
			// Word busy runs out on its own timer, so the exit word also finishes
			if (in_buffered_factory_program_mode && wr_take && !buffered_factory_program_mode_busy)
				buffered_factory_program_mode_busy <= 1'b1;
			else if (buffered_factory_program_mode_busy && buffered_factory_program_mode_tick == '0)
				buffered_factory_program_mode_busy <= 1'b0;
		end
	end

	// Factory word timer, one pulse long, separate from the controller's
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			buffered_factory_program_mode_tick <= '0;
		else if (!buffered_factory_program_mode_busy)
			buffered_factory_program_mode_tick <= PULSE_CYCLES - 8'h01;
		else if (buffered_factory_program_mode_tick != '0)
			buffered_factory_program_mode_tick <= buffered_factory_program_mode_tick - 8'h01;
	end

	// Bank bit: only meaningful while busy; factory mode reuses it for word readiness
	assign bank_write = in_buffered_factory_program_mode ? (buffered_factory_program_mode_busy && buffered_factory_program_mode_tick != '0)
		: (!ready && bank_of(BUS.addr) != op_bank);

	always_comb
	begin
		live_status            = '0;
		live_status[READY_POS] = ready;
		live_status[ESUSP_POS] = erase_susp;
		live_status[EERR_POS]  = erase_err;
		live_status[PERR_POS]  = prog_err;
		live_status[VERR_POS]  = supply_err;
		live_status[PSUSP_POS] = prog_susp;
		live_status[PROT_POS]  = prot_err;
		live_status[BANKW_POS] = bank_write;
	end

	status_latch u_latch (
		.clk_i    (MCLK_I),
		.rst_n_i  (RESET_N_I),
		.ce_n_i   (BUS.ce_n),
		.oe_n_i   (BUS.oe_n),
		.status_i (live_status),
		.status_o (held_status)
	);

	// Read mode: status after its command or, for the busy bank, after launch
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			rs_mode         <= 1'b0;
			op_reads_status <= 1'b0;
		end
		else if (wr_take && !await_data && !in_buffered_factory_program_mode && cmd == CMD_READ_ARRAY)
		begin
			rs_mode         <= 1'b0;
			op_reads_status <= 1'b0;
		end
		else
		begin
			rs_mode         <= rs_mode || (wr_take && !await_data && cmd == CMD_READ_STATUS);
			op_reads_status <= op_reads_status || go_run;
		end
	end

	// Registered bus drive; lags the strobe by one clock
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			BUS.dev_dq    <= '0;
			BUS.dev_dq_oe <= 1'b0;
		end
		else
		begin
			BUS.dev_dq_oe <= !BUS.ce_n && !BUS.oe_n;
			if (rs_mode || (op_reads_status && !ready && bank_of(BUS.addr) == op_bank))
				BUS.dev_dq <= {{(DATA_W-STAT_W){1'b0}}, held_status};
			else
				BUS.dev_dq <= ARRAY_DATA_I;
		end
	end

	// Observation outputs
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			BUSY_O   <= 1'b0;
			STATUS_O <= STATUS_RESET;
		end
		else
		begin
			BUSY_O   <= !ready;
			STATUS_O <= live_status;
		end
	end
endmodule

// *** verilog/flash_pe_host.sv ***
`timescale 1ns/1ps
module flash_pe_host
	import flash_status_pkg::*;
(
	// Clock and reset
	input  wire logic              MCLK_I,
	input  wire logic              RESET_N_I,
	// Flash bus
	flash_bus_if.host              BUS,
	// User request
	input  wire logic              CMD_VALID_I,
	input  wire logic              CMD_WRITE_I,
	input  wire logic [ADDR_W-1:0] CMD_ADDR_I,
	input  wire logic [DATA_W-1:0] CMD_DATA_I,
	output logic                   CMD_READY_O,
	// Read answer
	output logic                   RD_VALID_O,
	output logic      [DATA_W-1:0] RD_DATA_O,
	output logic      [3:0]        FLAGS_O
);
	import flash_status_pkg::*;

	host_state_t      state;
	logic             is_write;
	logic [CNT_W-1:0] cnt;
	logic [DATA_W-1:0] d;

	// Bus cycle sequencer: setup, strobe, release, end
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			state          <= H_IDLE;
			is_write       <= 1'b0;
			cnt            <= '0;
			CMD_READY_O    <= 1'b1;
			BUS.ce_n       <= 1'b1;
			BUS.oe_n       <= 1'b1;
			BUS.we_n       <= 1'b1;
			BUS.addr       <= '0;
			BUS.host_dq    <= '0;
			BUS.host_dq_oe <= 1'b0;
		end
		else
		begin
			case (state)
				H_IDLE:
				begin
					if (CMD_VALID_I)
					begin
						state          <= H_SETUP;
						CMD_READY_O    <= 1'b0;
						is_write       <= CMD_WRITE_I;
						BUS.ce_n       <= 1'b0;
						BUS.addr       <= CMD_ADDR_I;
						BUS.host_dq    <= CMD_DATA_I;
						BUS.host_dq_oe <= CMD_WRITE_I;
					end
				end
				H_SETUP:
				begin
					state    <= H_STROBE;
					cnt      <= STROBE_CYCLES;
					BUS.we_n <= !is_write;
					BUS.oe_n <= is_write;
				end
				H_STROBE:
				begin
					cnt <= cnt - 8'h01;
					if (cnt == 8'h01)
					begin
						state    <= H_RELEASE;
						BUS.we_n <= 1'b1;
						BUS.oe_n <= 1'b1;
					end
				end
				H_RELEASE:
				begin
					// Data and address held past the rising we_n
					state          <= H_END;
					BUS.ce_n       <= 1'b1;
					BUS.host_dq_oe <= 1'b0;
				end
				H_END:
				begin
					state       <= H_IDLE;
					CMD_READY_O <= 1'b1;
				end
				default:
					state <= H_IDLE;
			endcase
		end
	end

	// Read capture at the last strobe cycle
	assign d = BUS.dq;
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			RD_VALID_O <= 1'b0;
			RD_DATA_O  <= '0;
			FLAGS_O    <= '0;
		end
		else
		begin
			RD_VALID_O <= state == H_STROBE && cnt == 8'h01 && !is_write;
			if (state == H_STROBE && cnt == 8'h01 && !is_write)
			begin
				RD_DATA_O  <= d;
				// Bits qualified by the ready bit before use
				FLAGS_O[3] <= d[READY_POS] && (d[EERR_POS] || d[PERR_POS]);
				FLAGS_O[2] <= d[READY_POS] && d[ESUSP_POS];
				FLAGS_O[1] <= d[READY_POS] && d[PSUSP_POS];
				FLAGS_O[0] <= !d[READY_POS] && d[BANKW_POS];
			end
		end
	end
endmodule

// *** verilog/flash_status_pkg.sv ***
package flash_status_pkg;
	// Bus geometry
	localparam int DATA_W = 16;
	localparam int ADDR_W = 23;
	localparam int BANK_W = 4;
	localparam int STAT_W = 8;
	localparam int CNT_W  = 8;

	// Status bit positions
	localparam int READY_POS = 7;
	localparam int ESUSP_POS = 6;
	localparam int EERR_POS  = 5;
	localparam int PERR_POS  = 4;
	localparam int VERR_POS  = 3;
	localparam int PSUSP_POS = 2;
	localparam int PROT_POS  = 1;
	localparam int BANKW_POS = 0;
	localparam logic [STAT_W-1:0] STATUS_RESET = 8'h80;

	// Command codes, low byte of the data bus
	localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR       = 8'h50;
	localparam logic [7:0] CMD_ERASE       = 8'h20;
	localparam logic [7:0] CMD_PROGRAM     = 8'h40;
	localparam logic [7:0] CMD_BLANK       = 8'hbc;
	localparam logic [7:0] CMD_SUSPEND     = 8'hb0;
	localparam logic [7:0] CMD_RESUME      = 8'hd0;
	localparam logic [7:0] CMD_BUFFERED_FACTORY_PROGRAM_MODE        = 8'h80;
	localparam logic [ADDR_W-1:0] BUFFERED_FACTORY_PROGRAM_MODE_EXIT_ADDR = 23'h7fffff;

	// Timing, clock 25 ns
	localparam int CLK_PS       = 25000;
	localparam int PULSE_NS     = 1000;
	localparam int SUSP_LAT_NS  = 500;
	localparam int STROBE_NS    = 100;
	localparam logic [CNT_W-1:0] MAX_ERASE_PULSES = 8'h08;
	localparam logic [CNT_W-1:0] MAX_PROG_PULSES  = 8'h04;

	function automatic logic [CNT_W-1:0] cyc_ceil(input int ns);
		cyc_ceil = CNT_W'((ns * 1000 + CLK_PS - 1) / CLK_PS);
	endfunction
	function automatic logic [CNT_W-1:0] cyc_floor(input int ns);
		cyc_floor = CNT_W'(((ns * 1000 / CLK_PS) < 1) ? 1 : (ns * 1000 / CLK_PS));
	endfunction

	localparam logic [CNT_W-1:0] PULSE_CYCLES    = cyc_ceil(PULSE_NS);
	localparam logic [CNT_W-1:0] SUSP_LAT_CYCLES = cyc_floor(SUSP_LAT_NS);
	localparam logic [CNT_W-1:0] STROBE_CYCLES   = cyc_ceil(STROBE_NS);

	// Controller states, Gray along the path
	typedef enum logic [1:0] {ST_READY = 2'b00, ST_RUN = 2'b01, ST_SUSP_WAIT = 2'b11,
		ST_SUSPENDED = 2'b10} pe_state_t;
	typedef enum logic [1:0] {OP_ERASE = 2'b00, OP_PROGRAM = 2'b01, OP_BLANK = 2'b11} op_kind_t;
	typedef enum logic [2:0] {H_IDLE = 3'b000, H_SETUP = 3'b001, H_STROBE = 3'b011,
		H_RELEASE = 3'b010, H_END = 3'b110} host_state_t;

	function automatic logic [BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
		bank_of = a[ADDR_W-1 -: BANK_W];
	endfunction
endpackage

// *** verilog/status_latch.sv ***
`timescale 1ns/1ps
module status_latch
	import flash_status_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	// Strobes and live status
	input  wire logic              ce_n_i,
	input  wire logic              oe_n_i,
	input  wire logic [STAT_W-1:0] status_i,
	output logic      [STAT_W-1:0] status_o
);
	logic ce_n_q;
	logic oe_n_q;

	// Previous strobe levels for fall detection
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ce_n_q <= 1'b1;
			oe_n_q <= 1'b1;
		end
		else
		begin
			ce_n_q <= ce_n_i;
			oe_n_q <= oe_n_i;
		end
	end

	// Snapshot retaken at each ce_n or oe_n fall and held until the next one
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			status_o <= STATUS_RESET;
		else if ((ce_n_q && !ce_n_i) || (oe_n_q && !oe_n_i))
			status_o <= status_i;
	end
endmodule
